/* File: rtl/cfo_pkg.sv */
// Constants and types shared by the configuration and output select block.
package cfo_pkg;
    localparam int           CFO_DW          = 24;
    localparam logic [7:0]   CFO_PAGE_MAIN   = 8'h00;
    localparam logic [7:0]   CFO_PAGE_CAL    = 8'h12;
    localparam logic [5:0]   CFO_ADDR_CFG0   = 6'h00;
    localparam logic [5:0]   CFO_ADDR_CFG1   = 6'h01;
    localparam logic [5:0]   CFO_ADDR_V1DUR  = 6'h2e;
    localparam logic [5:0]   CFO_ADDR_V1LVL  = 6'h2f;
    localparam logic [5:0]   CFO_ADDR_V2DUR  = 6'h32;
    localparam logic [5:0]   CFO_ADDR_V2LVL  = 6'h33;
    localparam logic [5:0]   CFO_ADDR_VZXLVL = 6'h3a;
    localparam logic [5:0]   CFO_ADDR_LINE   = 6'h3e;
    localparam logic [5:0]   CFO_ADDR_SCALE  = 6'h3f;
    localparam int           CFO_NCAL        = 7;
    localparam logic [23:0]  CFO_RST_CFG0    = 24'h400000;
    localparam logic [23:0]  CFO_RST_CFG1    = 24'h00eeee;
    localparam logic [23:0]  CFO_RST_DUR     = 24'h000000;
    localparam logic [23:0]  CFO_RST_LVL     = 24'h7fffff;
    localparam logic [23:0]  CFO_RST_VZXLVL  = 24'h100000;
    localparam logic [23:0]  CFO_RST_LINE    = 24'h000064;
    localparam logic [23:0]  CFO_RST_SCALE   = 24'h4ccccc;
    localparam logic [23:0]  CFO_CFG0_WMASK  = 24'hb061f7;
    localparam logic [23:0]  CFO_CFG0_ONES   = 24'h400000;
    localparam int           CFO_TEMP_SEL    = 23;
    localparam int           CFO_CLK_INV     = 21;
    localparam int           CFO_CLK_EN      = 20;
    localparam int           CFO_CAP_LO      = 13;
    localparam int           CFO_IRQ_POL     = 8;
    localparam int           CFO_I2G_LO      = 6;
    localparam int           CFO_I1G_LO      = 4;
    localparam int           CFO_XTAL_DIS    = 2;
    localparam int           CFO_IZX_SRC     = 1;
    localparam int           CFO_VZX_SRC     = 0;
    localparam int           CFO_PGEN_LO     = 20;
    localparam int           CFO_DRAIN_LO    = 16;
    localparam logic [1:0]   CFO_GAIN_50X    = 2'h2;

    typedef enum logic [3:0] {
        CFO_M_PG1    = 4'b0000,
        CFO_M_PG2    = 4'b0001,
        CFO_M_PG3    = 4'b0010,
        CFO_M_PG4    = 4'b0011,
        CFO_M_P1     = 4'b0100,
        CFO_M_P2     = 4'b0101,
        CFO_M_SUMMED_ACTIVE_POWER   = 4'b0110,
        CFO_M_Q1     = 4'b0111,
        CFO_M_Q2     = 4'b1000,
        CFO_M_SUMMED_REACTIVE_POWER   = 4'b1001,
        CFO_M_RSV_A  = 4'b1010,
        CFO_M_VZX    = 4'b1011,
        CFO_M_IZX    = 4'b1100,
        CFO_M_RSV_D  = 4'b1101,
        CFO_M_HIZ    = 4'b1110,
        CFO_M_IRQ    = 4'b1111
    } cfo_mode_t;

    typedef struct packed {
        logic        we;
        logic [7:0]  page;
        logic [5:0]  addr;
        logic [23:0] data;
    } cfo_wr_t;

    typedef struct packed {
        logic [3:0] pulse;
        logic [5:0] sign;
        logic       vzx;
        logic       izx;
        logic       irq;
    } cfo_src_t;
endpackage : cfo_pkg

/* File: rtl/cfo_config_output.sv */
// Configuration words, calibration tail registers and digital output pin selection.
`timescale 1ns/100ps
// What this block does
// - All registers take listed defaults at reset.
// - Voltage crossing source bit picks channel 1/2.
// - Current crossing source bit picks channel 1/2.
// - Crystal disable stops oscillator, input becomes logic.
// - Interrupt polarity bit: 0 low, 1 high.
// - Gain code 00 is 10x, 10 is 50x.
// - Temperature select feeds sensor instead of channel 2.
// - Clock out enable and inversion control pin clock.
// - Pulse generators run only while enabled.
// - Drain select bit makes pin open-drain.
// - Modes 0000-0011 drive pulse generators 1-4.
// - Modes 0100-1001 drive six power signs.
// - Modes 1011/1100 drive selected zero crossings.
// - Mode 1110 high impedance, 1111 interrupt.
// - Averaging method picks checksum line or sample count.
module cfo_config_output
    import cfo_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        REG_WE,
    input  wire logic        REG_RE,
    input  wire logic [7:0]  REG_PAGE,
    input  wire logic [5:0]  REG_ADDR,
    input  wire logic [23:0] REG_WDATA,
    output logic      [23:0] REG_RDATA,
    output logic             REG_RVALID,
    input  wire logic [3:0]  PG_PULSE,
    input  wire logic [5:0]  POWER_SIGN,
    input  wire logic        V1_ZC,
    input  wire logic        V2_ZC,
    input  wire logic        I1_ZC,
    input  wire logic        I2_ZC,
    input  wire logic        IRQ_EVENT,
    input  wire logic        AVERAGING_METHOD,
    input  wire logic [23:0] SAMPLE_WINDOW_TOTAL,
    output logic             VZX_SELECTED,
    output logic             IZX_SELECTED,
    output logic             TEMP_SOURCE_SELECT,
    output logic [1:0]       SECOND_VOLTAGE_CAP_SIZE,
    output logic             CURRENT1_GAIN_50X,
    output logic             CURRENT2_GAIN_50X,
    output logic             CRYSTAL_OSC_RUN,
    output logic             CRYSTAL_INPUT_LOGIC,
    output logic             CLOCK_OUT_ENABLE,
    output logic             CLOCK_OUT_INVERT,
    output logic [3:0]       PULSE_GEN_ENABLE,
    output logic [23:0]      CHECKSUM_COUNT_WORD,
    output logic             CHECKSUM_USES_LINE,
    output logic [3:0]       DO_OUT,
    output logic [3:0]       DO_OE_N
);
    logic [23:0] main_config_word;
    logic [23:0] output_config_word;
    logic [23:0] calib [CFO_NCAL];
    logic        written;
    cfo_wr_t     wr;
    cfo_src_t    src;

    // Maps a calibration page address to its slot; bit 3 flags a hit.
    function automatic logic [3:0] cal_slot(input logic [5:0] a);
        case (a)
            CFO_ADDR_V1DUR:  cal_slot = 4'h8;
            CFO_ADDR_V1LVL:  cal_slot = 4'h9;
            CFO_ADDR_V2DUR:  cal_slot = 4'ha;
            CFO_ADDR_V2LVL:  cal_slot = 4'hb;
            CFO_ADDR_VZXLVL: cal_slot = 4'hc;
            CFO_ADDR_LINE:   cal_slot = 4'hd;
            CFO_ADDR_SCALE:  cal_slot = 4'he;
            default:         cal_slot = 4'h0;
        endcase
    endfunction : cal_slot

    function automatic logic [23:0] cal_reset(input int i);
        case (i)
            0, 2:    cal_reset = CFO_RST_DUR;
            1, 3:    cal_reset = CFO_RST_LVL;
            4:       cal_reset = CFO_RST_VZXLVL;
            5:       cal_reset = CFO_RST_LINE;
            default: cal_reset = CFO_RST_SCALE;
        endcase
    endfunction : cal_reset

    // Picks a pin's level; the second bit says whether the pin is driven at all.
    function automatic logic [1:0] pin_source(input cfo_mode_t m, input cfo_src_t s,
                                              input logic pol);
        case (m)
            CFO_M_PG1, CFO_M_PG2, CFO_M_PG3, CFO_M_PG4:
                pin_source = {1'b1, s.pulse[m[1:0]]};
            CFO_M_P1, CFO_M_P2, CFO_M_SUMMED_ACTIVE_POWER, CFO_M_Q1, CFO_M_Q2, CFO_M_SUMMED_REACTIVE_POWER:
                pin_source = {1'b1, s.sign[3'(m - CFO_M_P1)]};
            CFO_M_VZX: pin_source = {1'b1, s.vzx};
            CFO_M_IZX: pin_source = {1'b1, s.izx};
            CFO_M_IRQ: pin_source = {1'b1, pol ? s.irq : ~s.irq};
            // Reserved codes are held off the pin, like the idle code.
            default:   pin_source = 2'b00;
        endcase
    endfunction : pin_source

    assign wr = '{we: REG_WE, page: REG_PAGE, addr: REG_ADDR, data: REG_WDATA};

    wire         hit_cfg0 = wr.page == CFO_PAGE_MAIN && wr.addr == CFO_ADDR_CFG0;
    wire         hit_cfg1 = wr.page == CFO_PAGE_MAIN && wr.addr == CFO_ADDR_CFG1;
    wire  [3:0]  slot     = cal_slot(wr.addr);
    wire         hit_cal  = wr.page == CFO_PAGE_CAL && slot[3];
    wire  [2:0]  cal_idx  = slot[2:0];
    // Unpublished bits are not stored, so a careless host write cannot leak into them.
    wire  [23:0] next_cfg0 = (wr.data & CFO_CFG0_WMASK) | CFO_CFG0_ONES;
    wire  [23:0] rd_word  = hit_cfg0 ? main_config_word :
                            hit_cfg1 ? output_config_word :
                            hit_cal  ? calib[cal_idx] : 24'h000000;

    wire         vzx_src  = main_config_word[CFO_VZX_SRC];
    wire         izx_src  = main_config_word[CFO_IZX_SRC];
    wire         irq_pol  = main_config_word[CFO_IRQ_POL];
    wire  [1:0]  i1_gain  = main_config_word[CFO_I1G_LO +: 2];
    wire  [1:0]  i2_gain  = main_config_word[CFO_I2G_LO +: 2];
    wire  [3:0]  drain    = output_config_word[CFO_DRAIN_LO +: 4];
    wire         next_vzx = vzx_src ? V2_ZC : V1_ZC;
    wire         next_izx = izx_src ? I2_ZC : I1_ZC;
    wire  [23:0] next_csum_word = AVERAGING_METHOD ? calib[5] : SAMPLE_WINDOW_TOTAL;

    assign src = '{pulse: PG_PULSE, sign: POWER_SIGN, vzx: next_vzx, izx: next_izx,
                   irq: IRQ_EVENT};

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            main_config_word   <= CFO_RST_CFG0;
            output_config_word <= CFO_RST_CFG1;
            written            <= 1'b0;
        end else if (wr.we) begin
            if (hit_cfg0)
                main_config_word <= next_cfg0;
            if (hit_cfg1)
                output_config_word <= wr.data;
            written <= written | hit_cfg0 | hit_cfg1 | hit_cal;
        end
    end

    for (genvar i = 0; i < CFO_NCAL; i++) begin : g_cal
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN)
                calib[i] <= cal_reset(i);
            else if (wr.we && hit_cal && cal_idx == 3'(i))
                calib[i] <= wr.data;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA  <= 24'h000000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RDATA  <= REG_RE ? rd_word : REG_RDATA;
            REG_RVALID <= REG_RE;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            VZX_SELECTED            <= 1'b0;
            IZX_SELECTED            <= 1'b0;
            TEMP_SOURCE_SELECT      <= 1'b0;
            SECOND_VOLTAGE_CAP_SIZE <= 2'h0;
            CURRENT1_GAIN_50X       <= 1'b0;
            CURRENT2_GAIN_50X       <= 1'b0;
            CRYSTAL_OSC_RUN         <= 1'b1;
            CRYSTAL_INPUT_LOGIC     <= 1'b0;
            CLOCK_OUT_ENABLE        <= 1'b0;
            CLOCK_OUT_INVERT        <= 1'b0;
            PULSE_GEN_ENABLE        <= 4'h0;
            CHECKSUM_COUNT_WORD     <= 24'h000000;
            CHECKSUM_USES_LINE      <= 1'b0;
        end else begin
            VZX_SELECTED            <= next_vzx;
            IZX_SELECTED            <= next_izx;
            TEMP_SOURCE_SELECT      <= main_config_word[CFO_TEMP_SEL];
            SECOND_VOLTAGE_CAP_SIZE <= main_config_word[CFO_CAP_LO +: 2];
            // Undefined gain codes fall back to the low gain setting.
            CURRENT1_GAIN_50X       <= i1_gain == CFO_GAIN_50X;
            CURRENT2_GAIN_50X       <= i2_gain == CFO_GAIN_50X;
            CRYSTAL_OSC_RUN         <= !main_config_word[CFO_XTAL_DIS];
            CRYSTAL_INPUT_LOGIC     <= main_config_word[CFO_XTAL_DIS];
            CLOCK_OUT_ENABLE        <= main_config_word[CFO_CLK_EN];
            CLOCK_OUT_INVERT        <= main_config_word[CFO_CLK_INV];
            PULSE_GEN_ENABLE        <= output_config_word[CFO_PGEN_LO +: 4];
            CHECKSUM_COUNT_WORD     <= next_csum_word;
            CHECKSUM_USES_LINE      <= AVERAGING_METHOD;
        end
    end

    for (genvar p = 0; p < 4; p++) begin : g_pin
        wire [1:0] sel      = pin_source(cfo_mode_t'(output_config_word[4*p +: 4]), src,
                                         irq_pol);
        // An open-drain pin only ever pulls low; a high level releases it.
        wire       next_oe_n = drain[p] ? !(sel[1] && !sel[0]) : !sel[1];
        wire       next_out  = drain[p] ? 1'b0 : sel[0];
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                DO_OUT[p]  <= 1'b0;
                DO_OE_N[p] <= 1'b1;
            end else begin
                DO_OUT[p]  <= next_out;
                DO_OE_N[p] <= next_oe_n;
            end
        end
    end

    wire [3:0] mode0 = output_config_word[3:0];

    chk_reset_defaults: assert property (@(posedge CLK) disable iff (!RESETN)
        !written |-> main_config_word == CFO_RST_CFG0 && output_config_word == CFO_RST_CFG1
            && calib[1] == CFO_RST_LVL && calib[5] == CFO_RST_LINE)
        else $error("register left its default without a write");

    chk_vzx_route: assert property (@(posedge CLK) disable iff (!RESETN)
        ##1 VZX_SELECTED == ($past(vzx_src) ? $past(V2_ZC) : $past(V1_ZC)))
        else $error("voltage crossing source wrong");

    chk_izx_route: assert property (@(posedge CLK) disable iff (!RESETN)
        ##1 IZX_SELECTED == ($past(izx_src) ? $past(I2_ZC) : $past(I1_ZC)))
        else $error("current crossing source wrong");

    chk_crystal_mode: assert property (@(posedge CLK) disable iff (!RESETN)
        CRYSTAL_OSC_RUN != CRYSTAL_INPUT_LOGIC)
        else $error("oscillator and logic input both on or off");

    chk_gain_decode: assert property (@(posedge CLK) disable iff (!RESETN)
        $changed(i1_gain) |=> CURRENT1_GAIN_50X == ($past(i1_gain) == 2'h2))
        else $error("gain decode wrong");

    chk_pulse_enable: assert property (@(posedge CLK) disable iff (!RESETN)
        wr.we && hit_cfg1 |-> ##2 PULSE_GEN_ENABLE == $past(wr.data[23:20], 2))
        else $error("pulse generator enable not applied");

    chk_drain_low: assert property (@(posedge CLK) disable iff (!RESETN)
        $past(drain[0]) && !DO_OE_N[0] |-> !DO_OUT[0])
        else $error("open-drain pin driven high");

    chk_idle_hiz: assert property (@(posedge CLK) disable iff (!RESETN)
        mode0 == CFO_M_HIZ |=> DO_OE_N[0])
        else $error("idle pin is driven");

    chk_irq_level: assert property (@(posedge CLK) disable iff (!RESETN)
        mode0 == CFO_M_IRQ && !drain[0] |=> !DO_OE_N[0]
            && DO_OUT[0] == ($past(irq_pol) ? $past(IRQ_EVENT) : !$past(IRQ_EVENT)))
        else $error("interrupt pin polarity wrong");

    chk_pulse_route: assert property (@(posedge CLK) disable iff (!RESETN)
        mode0 == CFO_M_PG3 && !drain[0] |=> DO_OUT[0] == $past(PG_PULSE[2]))
        else $error("pulse generator not routed");

    chk_sign_route: assert property (@(posedge CLK) disable iff (!RESETN)
        mode0 == CFO_M_SUMMED_REACTIVE_POWER && !drain[0] |=> DO_OUT[0] == $past(POWER_SIGN[5]))
        else $error("power sign not routed");

    chk_csum_select: assert property (@(posedge CLK) disable iff (!RESETN)
        AVERAGING_METHOD ##1 AVERAGING_METHOD |-> CHECKSUM_COUNT_WORD == $past(calib[5]))
        else $error("checksum count word wrong");

    cov_irq_pin: cover property (@(posedge CLK) disable iff (!RESETN)
        mode0 == CFO_M_IRQ ##1 !DO_OE_N[0]);
    cov_drain_release: cover property (@(posedge CLK) disable iff (!RESETN)
        drain[0] && mode0 == CFO_M_PG1 ##1 DO_OE_N[0]);
    cov_cal_write: cover property (@(posedge CLK) disable iff (!RESETN)
        wr.we && hit_cal ##1 REG_RE);
endmodule : cfo_config_output

/* File: tb/cfo_pin_partner.sv */
// Pin-side partner: the digital output pads as an external pulse counter sees them.
`timescale 1ns/100ps
module cfo_pin_partner
    import cfo_pkg::*;
(
    input  wire logic [3:0] do_out,
    input  wire logic [3:0] do_oe_n,
    output logic      [3:0] pad
);
    // The counter side carries a pull-up, so a released pad reads 1 and never a stale level.
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            pad[p] = do_oe_n[p] ? 1'b1 : do_out[p];
        end
    end
endmodule : cfo_pin_partner

/* File: tb/cfo_config_output_bench.sv */
// Self-checking bench for the configuration words and digital output pin selection.
`timescale 1ns/100ps
module cfo_config_output_bench
    import cfo_pkg::*;
;
    logic        clk, resetn, reg_we, reg_re, reg_rvalid, v1_zc, v2_zc, i1_zc, i2_zc;
    logic        irq_event, avg_method, vzx_sel, izx_sel, temp_sel, i1_50x, i2_50x;
    logic        osc_run, xin_logic, clk_en, clk_inv, csum_line;
    logic [7:0]  reg_page;
    logic [5:0]  reg_addr;
    logic [23:0] reg_wdata, reg_rdata, sample_total, csum_word;
    logic [3:0]  pg_pulse, pg_en, do_out, do_oe_n, pad, mode;
    logic [5:0]  power_sign;
    logic [1:0]  cap_size;
    logic [8:0]  flags;
    logic [14:0] src;
    logic        drives;
    cfo_wr_t     defaults [9];
    int          n_errors, tests_run;

    assign flags = {temp_sel, clk_inv, clk_en, cap_size, i2_50x, i1_50x, osc_run, xin_logic};

    cfo_config_output DUT (.CLK(clk), .RESETN(resetn), .REG_WE(reg_we), .REG_RE(reg_re),
        .REG_PAGE(reg_page), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .PG_PULSE(pg_pulse), .POWER_SIGN(power_sign), .V1_ZC(v1_zc),
        .V2_ZC(v2_zc), .I1_ZC(i1_zc), .I2_ZC(i2_zc), .IRQ_EVENT(irq_event),
        .AVERAGING_METHOD(avg_method), .SAMPLE_WINDOW_TOTAL(sample_total),
        .VZX_SELECTED(vzx_sel), .IZX_SELECTED(izx_sel), .TEMP_SOURCE_SELECT(temp_sel),
        .SECOND_VOLTAGE_CAP_SIZE(cap_size), .CURRENT1_GAIN_50X(i1_50x),
        .CURRENT2_GAIN_50X(i2_50x), .CRYSTAL_OSC_RUN(osc_run), .CRYSTAL_INPUT_LOGIC(xin_logic),
        .CLOCK_OUT_ENABLE(clk_en), .CLOCK_OUT_INVERT(clk_inv), .PULSE_GEN_ENABLE(pg_en),
        .CHECKSUM_COUNT_WORD(csum_word), .CHECKSUM_USES_LINE(csum_line), .DO_OUT(do_out),
        .DO_OE_N(do_oe_n));

    cfo_pin_partner partner (.do_out(do_out), .do_oe_n(do_oe_n), .pad(pad));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] page, input logic [5:0] addr, input logic [23:0] data);
        @(negedge clk);
        reg_we = 1'b1;
        reg_page = page;
        reg_addr = addr;
        reg_wdata = data;
        @(negedge clk);
        reg_we = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] page, input logic [5:0] addr, input logic [23:0] exp);
        @(negedge clk);
        reg_re = 1'b1;
        reg_page = page;
        reg_addr = addr;
        @(negedge clk);
        reg_re = 1'b0;
        chk("read valid", 24'h1, {23'h0, reg_rvalid});
        chk("read data", exp, reg_rdata);
    endtask : rd

    // Sources as one vector: pulses 3:0, signs 9:4, V1 10, I1 11, interrupt 12, V2 13, I2 14.
    task automatic set_src(input logic [14:0] s);
        pg_pulse = s[3:0];
        power_sign = s[9:4];
        v1_zc = s[10];
        i1_zc = s[11];
        irq_event = s[12];
        v2_zc = s[13];
        i2_zc = s[14];
        // Selected crossings feed the pin register directly, with no register stage ahead of it.
        repeat (2) @(negedge clk);
    endtask : set_src

    function automatic int src_idx(input logic [3:0] m);
        case (m)
            4'hb: return 10;
            4'hc: return 11;
            4'hf: return 12;
            default: return int'(m);
        endcase
    endfunction : src_idx

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        {resetn, reg_we, reg_re, reg_page, reg_addr, reg_wdata, avg_method} = '0;
        {pg_pulse, power_sign, v1_zc, v2_zc, i1_zc, i2_zc, irq_event} = '0;
        sample_total = 24'h000000;
        defaults = '{'{1'b0, CFO_PAGE_MAIN, CFO_ADDR_CFG0, 24'h400000},
                     '{1'b0, CFO_PAGE_MAIN, CFO_ADDR_CFG1, 24'h00eeee},
                     '{1'b0, CFO_PAGE_CAL, CFO_ADDR_V1DUR, 24'h000000},
                     '{1'b0, CFO_PAGE_CAL, CFO_ADDR_V1LVL, 24'h7fffff},
                     '{1'b0, CFO_PAGE_CAL, CFO_ADDR_V2DUR, 24'h000000},
                     '{1'b0, CFO_PAGE_CAL, CFO_ADDR_V2LVL, 24'h7fffff},
                     '{1'b0, CFO_PAGE_CAL, CFO_ADDR_VZXLVL, 24'h100000},
                     '{1'b0, CFO_PAGE_CAL, CFO_ADDR_LINE, 24'h000064},
                     '{1'b0, CFO_PAGE_CAL, CFO_ADDR_SCALE, 24'h4ccccc}};
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        foreach (defaults[i]) rd(defaults[i].page, defaults[i].addr, defaults[i].data);
        chk("idle flags", 24'h000002, {15'h0, flags});
        chk("idle enables", 24'h00000f, {16'h0, pg_en, do_oe_n});
        // Legal values only: bit 22 kept at 1, capacitor field 01, gains 10.
        wr(CFO_PAGE_MAIN, CFO_ADDR_CFG0, 24'hf021a7);
        set_src(15'h0000);
        chk("set flags", 24'h0001dd, {15'h0, flags});
        rd(CFO_PAGE_MAIN, CFO_ADDR_CFG0, 24'hf021a7);
        rd(CFO_PAGE_MAIN, 6'h02, 24'h000000);
        rd(CFO_PAGE_CAL, 6'h2d, 24'h000000);
        // Channel 2 crossings high, channel 1 low, pins 0 and 1 on the crossing modes.
        wr(CFO_PAGE_MAIN, CFO_ADDR_CFG1, 24'h00eecb);
        set_src(15'h6000);
        chk("crossing ch2", 24'h000fc3, {12'h0, vzx_sel, izx_sel, 2'b11, do_oe_n, do_out});
        wr(CFO_PAGE_MAIN, CFO_ADDR_CFG0, 24'h400100);
        set_src(15'h6000);
        chk("crossing ch1", 24'h0003c0, {12'h0, vzx_sel, izx_sel, 2'b11, do_oe_n, do_out});
        // Every mode on all four pins: the selected source differs from all the others.
        for (int m = 0; m < 16; m++) begin
            mode = 4'(m);
            drives = !(m == 10 || m == 13 || m == 14);
            wr(CFO_PAGE_MAIN, CFO_ADDR_CFG1, {8'h00, mode, mode, mode, mode});
            for (int ph = 0; ph < 2; ph++) begin
                src = 15'h1 << src_idx(mode);
                set_src(ph ? src : ~src);
                chk("pin mode", {16'h0, {4{~drives}}, {4{drives & ph[0]}}}, {16'h0, do_oe_n, do_out});
            end
        end
        // Pins 0 and 2 open drain, generators 2 and 4 enabled, interrupt active high.
        wr(CFO_PAGE_MAIN, CFO_ADDR_CFG1, 24'ha5ffff);
        set_src(15'h1000);
        chk("od high", 24'h00a5af, {8'h0, pg_en, do_oe_n, do_out, pad});
        set_src(15'h0000);
        chk("od low", 24'h000000, {12'h0, do_oe_n, do_out, pad});
        wr(CFO_PAGE_MAIN, CFO_ADDR_CFG0, 24'h400000);
        set_src(15'h1000);
        chk("active low on", 24'h000000, {12'h0, do_oe_n, do_out, pad});
        set_src(15'h0000);
        chk("active low off", 24'h0005af, {12'h0, do_oe_n, do_out, pad});
        // Checksum word follows the averaging method.
        wr(CFO_PAGE_CAL, CFO_ADDR_LINE, 24'h000123);
        avg_method = 1'b1;
        sample_total = 24'h00abcd;
        set_src(15'h0000);
        chk("sum line", 24'h000123, csum_word);
        chk("sum line flag", 24'h000001, {23'h0, csum_line});
        avg_method = 1'b0;
        set_src(15'h0000);
        chk("sum samples", 24'h00abcd, csum_word);
        chk("sum samples flag", 24'h000000, {23'h0, csum_line});
        // A second reset in mid-run restores the defaults.
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        rd(CFO_PAGE_MAIN, CFO_ADDR_CFG1, 24'h00eeee);
        rd(CFO_PAGE_CAL, CFO_ADDR_LINE, 24'h000064);
        tally_and_finish();
    end
endmodule : cfo_config_output_bench
